// ### src/hmc_halt_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none

module hmc_halt_mode_controller (
   input  wire logic                        clk_i,
   input  wire logic                        sys_rst_i,
   input  wire logic                        ce_i,
   // Register port
   input  wire logic [hmc_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [hmc_pkg::DATA_W-1:0]  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output var  logic [hmc_pkg::DATA_W-1:0]  rdata_o,
   // CPU and interrupt side
   input  wire logic                        halt_exec_i,
   input  wire logic                        lite_timer_irq_i,
   input  wire logic                        reload_timer_irq_i,
   input  wire logic                        awu_irq_i,
   input  wire logic [hmc_pkg::IRQ_W-1:0]   irq_req_i,
   input  wire logic                        rst_pin_n_i,
   // Watchdog side
   input  wire logic                        wdg_active_i,
   input  wire logic                        watchdog_halt_option_i,
   // Controls
   output var  hmc_pkg::hmc_clk_t           clk_en_o,
   output var  logic                        imask_clear_o,
   output var  logic                        irq_service_o,
   output var  logic                        fetch_rst_vec_o,
   output var  logic                        wdg_rst_o,
   output var  hmc_pkg::hmc_cause_t         wake_cause_o
);

   typedef struct packed {
      hmc_pkg::hmc_state_t  st;
      hmc_pkg::hmc_cfg_t    cfg;
      logic [7:0]           mask;
      hmc_pkg::hmc_clk_t    clk;
      logic                 imask_clr;
      logic                 irq_srv;
      logic                 rst_fetch;
      logic                 wdg_rst;
      hmc_pkg::hmc_cause_t  cause;
      logic                 pend_rst;
      logic                 go;
      logic [7:0]           rdata;
      logic [1:0]           rsync;
   } hmc_regs_t;

   localparam hmc_regs_t REG_RST = '{st: hmc_pkg::ST_RUN, cfg: hmc_pkg::CFG_RST, mask: hmc_pkg::WAKE_MASK_RST,
                                     clk: hmc_pkg::CLK_RUN, imask_clr: 1'b0, irq_srv: 1'b0, rst_fetch: 1'b0,
                                     wdg_rst: 1'b0, cause: hmc_pkg::CS_NONE, pend_rst: 1'b0, go: 1'b0,
                                     rdata: 8'h00, rsync: 2'b11};

   hmc_regs_t r_reg;
   hmc_regs_t r_next;
   logic      dly_done;
   logic      dly_busy;
   logic      ah_en;
   logic      rst_req;
   logic      timer_irq;
   logic      ext_wake;
   logic      wdg_fire;

   // Oscillator stabilisation counter
   hmc_stab_delay u_stab (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .start_i   (r_reg.go),
      .busy_o    (dly_busy),
      .done_o    (dly_done)
   );

   // Mode decision and wake conditions
   always_comb begin
      ah_en     = r_reg.cfg.timebase_irq_enable |
                  (r_reg.cfg.overflow_irq_enable & ~r_reg.cfg.at_clock_select_hi &
                   r_reg.cfg.at_clock_select_lo);
      rst_req   = ~r_reg.rsync[1];
      timer_irq = lite_timer_irq_i | reload_timer_irq_i;
      ext_wake  = |(irq_req_i & r_reg.mask);
      wdg_fire  = wdg_active_i & ~watchdog_halt_option_i & ~ah_en;
   end

   // Next-state logic for the mode machine and register port
   always_comb begin
      r_next           = r_reg;
      r_next.rsync     = {r_reg.rsync[0], rst_pin_n_i};
      r_next.imask_clr = 1'b0;
      r_next.irq_srv   = 1'b0;
      r_next.rst_fetch = 1'b0;
      r_next.wdg_rst   = 1'b0;
      r_next.go        = 1'b0;
      r_next.rdata     = 8'h00;

      // Register writes and reads
      if (wr_i) begin
         if (addr_i == hmc_pkg::CFG_OFS) begin
            r_next.cfg      = hmc_pkg::hmc_cfg_t'(wdata_i);
            r_next.cfg.rsvd = 3'h0;
         end else if (addr_i == hmc_pkg::WAKE_MASK_OFS) begin
            r_next.mask = wdata_i;
         end
      end
      if (rd_i) begin
         if (addr_i == hmc_pkg::CFG_OFS) begin
            r_next.rdata = r_reg.cfg;
         end else if (addr_i == hmc_pkg::WAKE_MASK_OFS) begin
            r_next.rdata = r_reg.mask;
         end else if (addr_i == hmc_pkg::STAT_OFS) begin
            r_next.rdata = {1'b0, dly_busy, r_reg.cause, ah_en, r_reg.st};
         end
      end

      case (r_reg.st)
         // Run: watchdog reset or choice of halt flavour on halt
         hmc_pkg::ST_RUN: begin
            if (rst_req) begin
               r_next.st = hmc_pkg::ST_RST_WAIT;
            end else if (halt_exec_i && wdg_fire) begin
               r_next.wdg_rst = 1'b1;
            end else if (halt_exec_i) begin
               r_next.imask_clr = 1'b1;
               r_next.clk.cpu    = 1'b0;
               r_next.clk.periph = 1'b0;
               if (ah_en) begin
                  r_next.st               = hmc_pkg::ST_ACT_HALT;
                  r_next.clk.osc          = 1'b1;
                  r_next.clk.lite_timer   = r_reg.cfg.timebase_irq_enable;
                  r_next.clk.reload_timer = ~r_reg.cfg.timebase_irq_enable;
                  r_next.clk.wdg          = 1'b1;
               end else begin
                  r_next.st               = r_reg.cfg.auto_wakeup_enable ?
                                            hmc_pkg::ST_AWU_HALT : hmc_pkg::ST_HALT;
                  r_next.clk.osc          = 1'b0;
                  r_next.clk.lite_timer   = 1'b0;
                  r_next.clk.reload_timer = 1'b0;
                  r_next.clk.wdg          = 1'b0;
                  r_next.clk.awu_osc      = r_reg.cfg.auto_wakeup_enable;
               end
            end
         end
         // Active-halt: timer wake is immediate, no delay
         hmc_pkg::ST_ACT_HALT: begin
            if (rst_req) begin
               r_next.st = hmc_pkg::ST_RST_WAIT;
            end else if (timer_irq) begin
               r_next.st      = hmc_pkg::ST_RUN;
               r_next.clk     = hmc_pkg::CLK_RUN;
               r_next.irq_srv = 1'b1;
               r_next.cause   = hmc_pkg::CS_TIMER;
            end
         end
         // Full halt: masked request or auto-wakeup starts the delay
         hmc_pkg::ST_HALT,
         hmc_pkg::ST_AWU_HALT: begin
            if (rst_req) begin
               r_next.st = hmc_pkg::ST_RST_WAIT;
            end else if (ext_wake || (r_reg.st == hmc_pkg::ST_AWU_HALT && awu_irq_i)) begin
               r_next.st          = hmc_pkg::ST_STAB;
               r_next.go          = 1'b1;
               r_next.pend_rst    = 1'b0;
               r_next.clk.osc     = 1'b1;
               r_next.clk.awu_osc = 1'b0;
               r_next.cause       = ext_wake ? hmc_pkg::CS_EXT : hmc_pkg::CS_AWU;
            end
         end
         // Reset pin held: wait for release, then start the delay
         hmc_pkg::ST_RST_WAIT: begin
            r_next.clk = '0;
            r_next.clk.osc = 1'b1;
            if (!rst_req) begin
               r_next.st       = hmc_pkg::ST_STAB;
               r_next.go       = 1'b1;
               r_next.pend_rst = 1'b1;
            end
         end
         // A done pulse left from a cut delay must not end the fresh one
         hmc_pkg::ST_STAB: begin
            if (rst_req) begin
               r_next.st = hmc_pkg::ST_RST_WAIT;
            end else if (dly_done && !r_reg.go) begin
               r_next.st        = hmc_pkg::ST_RUN;
               r_next.clk       = hmc_pkg::CLK_RUN;
               r_next.rst_fetch = r_reg.pend_rst;
               r_next.irq_srv   = ~r_reg.pend_rst;
            end
         end
         default: begin
            r_next.st = hmc_pkg::ST_RUN;
         end
      endcase
   end

   // State register with clock enable
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         r_reg <= REG_RST;
      end else if (ce_i) begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register
   assign rdata_o         = r_reg.rdata;
   assign clk_en_o        = r_reg.clk;
   assign imask_clear_o   = r_reg.imask_clr;
   assign irq_service_o   = r_reg.irq_srv;
   assign fetch_rst_vec_o = r_reg.rst_fetch;
   assign wdg_rst_o       = r_reg.wdg_rst;
   assign wake_cause_o    = r_reg.cause;

   // Checks
   localparam int AGE_AT_DONE = hmc_pkg::STAB_CPU_CYCLES + 1;
   logic [9:0] stab_age;

   // Cycles spent in the stabilisation state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         stab_age <= 10'h000;
      end else if (ce_i) begin
         stab_age <= (r_reg.st == hmc_pkg::ST_STAB) ? stab_age + 10'h001 : 10'h000;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_halt_req;
      r_reg.st == hmc_pkg::ST_RUN && halt_exec_i && !rst_req && ce_i;
   endsequence

   sequence s_ah_wake;
      r_reg.st == hmc_pkg::ST_ACT_HALT && !rst_req && timer_irq && ce_i;
   endsequence

   sequence s_stab_done;
      r_reg.st == hmc_pkg::ST_STAB && dly_done && !r_reg.go && !rst_req && ce_i;
   endsequence

   sequence s_full_wake;
      r_reg.st inside {hmc_pkg::ST_HALT, hmc_pkg::ST_AWU_HALT} && ext_wake && !rst_req && ce_i;
   endsequence

   // Mode entry, clocks and wakeups
   AST_ENTER_ACTIVE: assert property (s_halt_req and ah_en |=> r_reg.st == hmc_pkg::ST_ACT_HALT)
      else $error("active-halt not entered");
   AST_ENTER_FULL: assert property (s_halt_req and !ah_en && !wdg_fire |=>
      r_reg.st == ($past(r_reg.cfg.auto_wakeup_enable) ? hmc_pkg::ST_AWU_HALT : hmc_pkg::ST_HALT))
      else $error("wrong halt flavour entered");
   AST_AH_STAYS: assert property (r_reg.st == hmc_pkg::ST_ACT_HALT && !rst_req && !timer_irq |=>
      r_reg.st == hmc_pkg::ST_ACT_HALT)
      else $error("active-halt left without cause");
   AST_AH_IRQ_FAST: assert property (s_ah_wake |=> r_reg.st == hmc_pkg::ST_RUN && irq_service_o ##1
      !irq_service_o)
      else $error("timer wake not immediate");
   AST_STAB_LEN: assert property (r_reg.st == hmc_pkg::ST_STAB && dly_done && !r_reg.go |->
      stab_age == AGE_AT_DONE)
      else $error("stabilisation delay wrong length");
   AST_STAB_EXIT: assert property (r_reg.st == hmc_pkg::ST_STAB && !dly_done && !rst_req && ce_i |=>
      r_reg.st == hmc_pkg::ST_STAB && clk_en_o.osc && !clk_en_o.cpu)
      else $error("left stabilisation early");
   AST_IMASK_CLR: assert property (s_halt_req and !wdg_fire |=> imask_clear_o)
      else $error("interrupt mask not cleared on entry");
   AST_AH_CLOCKS: assert property (r_reg.st == hmc_pkg::ST_ACT_HALT |-> clk_en_o.osc && !clk_en_o.periph
      && !clk_en_o.cpu && (clk_en_o.lite_timer != clk_en_o.reload_timer))
      else $error("active-halt clock gating wrong");
   AST_HALT_CLOCKS: assert property (r_reg.st inside {hmc_pkg::ST_HALT, hmc_pkg::ST_AWU_HALT} |->
      !clk_en_o.osc && !clk_en_o.periph && !clk_en_o.cpu && !clk_en_o.wdg)
      else $error("full halt clocks not stopped");
   AST_WDG_AH: assert property (s_halt_req and ah_en |=> !wdg_rst_o && clk_en_o.wdg)
      else $error("watchdog reset in active-halt");
   AST_WDG_HALT: assert property (s_halt_req and wdg_fire |=> wdg_rst_o && r_reg.st == hmc_pkg::ST_RUN)
      else $error("watchdog halt reset missing");
   AST_SRV_SRC: assert property ($rose(irq_service_o) |->
      $past(r_reg.st) inside {hmc_pkg::ST_ACT_HALT, hmc_pkg::ST_STAB})
      else $error("service pulse from wrong state");
   AST_EXT_WAKE: assert property (r_reg.st == hmc_pkg::ST_HALT && !rst_req && ce_i |=>
      r_reg.st == ($past(ext_wake) ? hmc_pkg::ST_STAB : hmc_pkg::ST_HALT))
      else $error("masked wake vector not honoured");

   // Exit paths and clocks while halted
   AST_RST_ENTRY: assert property (r_reg.st != hmc_pkg::ST_RST_WAIT && rst_req && ce_i |=>
      r_reg.st == hmc_pkg::ST_RST_WAIT)
      else $error("reset pin not honoured");
   AST_RST_WAIT_CLK: assert property (r_reg.st == hmc_pkg::ST_RST_WAIT && ce_i |=>
      clk_en_o.osc && !clk_en_o.cpu && !clk_en_o.periph)
      else $error("reset wait clocks wrong");
   AST_RST_FETCH: assert property (s_stab_done and r_reg.pend_rst |=>
      r_reg.st == hmc_pkg::ST_RUN && fetch_rst_vec_o && !irq_service_o)
      else $error("reset vector fetch missing after delay");
   AST_HALT_SRV: assert property (s_stab_done and !r_reg.pend_rst |=>
      irq_service_o && !fetch_rst_vec_o && clk_en_o == hmc_pkg::CLK_RUN)
      else $error("wake service missing after delay");
   AST_FULL_WAKE: assert property (s_full_wake |=>
      r_reg.st == hmc_pkg::ST_STAB && clk_en_o.osc && !clk_en_o.cpu ##1 dly_busy)
      else $error("oscillator restart or delay start missing");
   AST_AWU_WAKE: assert property (r_reg.st == hmc_pkg::ST_AWU_HALT && awu_irq_i && !rst_req && ce_i |=>
      r_reg.st == hmc_pkg::ST_STAB && !clk_en_o.awu_osc)
      else $error("auto-wakeup did not start the delay");
   AST_AWU_OSC: assert property (r_reg.st == hmc_pkg::ST_AWU_HALT |->
      clk_en_o.awu_osc && !clk_en_o.osc)
      else $error("auto-wakeup oscillator gating wrong");

   // Entry side, register port and clock enable
   AST_HALT_IGNORED: assert property (r_reg.st != hmc_pkg::ST_RUN && ce_i |=>
      !imask_clear_o && !wdg_rst_o)
      else $error("halt acted on outside run");
   AST_PULSE_ONE: assert property (imask_clear_o && ce_i |=>
      !imask_clear_o)
      else $error("mask clear pulse too long");
   AST_AH_TIMER_SEL: assert property (s_halt_req and ah_en |=>
      clk_en_o.lite_timer == $past(r_reg.cfg.timebase_irq_enable))
      else $error("wrong wakeup timer kept running");
   AST_WDG_OPT: assert property (s_halt_req and !ah_en && watchdog_halt_option_i |=>
      !wdg_rst_o && r_reg.st != hmc_pkg::ST_RUN)
      else $error("watchdog reset despite option set");
   AST_RDATA_IDLE: assert property (!rd_i && ce_i |=> // Register port
      rdata_o == 8'h00)
      else $error("read data outside the answer cycle");
   AST_CE_FREEZE: assert property (!ce_i |=> // Freeze
      $stable(r_reg))
      else $error("state moved with clock enable low");

endmodule : hmc_halt_mode_controller

`default_nettype wire

// ### common/hmc_pkg.sv
package hmc_pkg;

   // Register port geometry
   localparam int          ADDR_W           = 2;
   localparam int          DATA_W           = 8;
   localparam int          IRQ_W            = 8;

   // Register offsets
   localparam logic [1:0]  CFG_OFS          = 2'h0;
   localparam logic [1:0]  WAKE_MASK_OFS    = 2'h1;
   localparam logic [1:0]  STAT_OFS         = 2'h2;

   // Reset values
   localparam logic [7:0]  CFG_RST          = 8'h00;
   localparam logic [7:0]  WAKE_MASK_RST    = 8'hff;

   // Oscillator stabilisation delay, in CPU cycles (one CPU cycle per clk_i)
   localparam int          STAB_CPU_CYCLES  = 256;
   localparam int          CNT_W            = 9;
   localparam logic [8:0]  STAB_COUNT       = 9'(STAB_CPU_CYCLES);

   // Configuration register layout, bit 0 at the right
   typedef struct packed {
      logic [2:0] rsvd;
      logic       auto_wakeup_enable;
      logic       at_clock_select_hi;
      logic       at_clock_select_lo;
      logic       overflow_irq_enable;
      logic       timebase_irq_enable;
   } hmc_cfg_t;

   // Controller modes
   typedef enum logic [2:0] {
      ST_RUN,
      ST_ACT_HALT,
      ST_HALT,
      ST_AWU_HALT,
      ST_RST_WAIT,
      ST_STAB
   } hmc_state_t;

   // Cause of the last wakeup
   typedef enum logic [1:0] {
      CS_NONE,
      CS_TIMER,
      CS_EXT,
      CS_AWU
   } hmc_cause_t;

   // Clock gate bundle
   typedef struct packed {
      logic cpu;
      logic osc;
      logic periph;
      logic lite_timer;
      logic reload_timer;
      logic wdg;
      logic awu_osc;
   } hmc_clk_t;

   localparam hmc_clk_t    CLK_RUN          = '{cpu: 1'b1, osc: 1'b1, periph: 1'b1, lite_timer: 1'b1,
                                                reload_timer: 1'b1, wdg: 1'b1, awu_osc: 1'b0};

endpackage : hmc_pkg

// ### src/hmc_stab_delay.sv
`timescale 1ns/1ps
`default_nettype none

module hmc_stab_delay (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   input  wire logic start_i,
   output var  logic busy_o,
   output var  logic done_o
);

   typedef struct packed {
      logic [hmc_pkg::CNT_W-1:0] cnt;
      logic                      done;
   } hmc_dly_regs_t;

   hmc_dly_regs_t r_reg;
   hmc_dly_regs_t r_next;

   // Load on start, count down, pulse done on the last count
   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      if (start_i) begin
         r_next.cnt = hmc_pkg::STAB_COUNT;
      end else if (r_reg.cnt != '0) begin
         r_next.cnt  = r_reg.cnt - 9'h001;
         r_next.done = (r_reg.cnt == 9'h001);
      end
   end

   // State register with clock enable
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         r_reg <= '0;
      end else if (ce_i) begin
         r_reg <= r_next;
      end
   end

   assign busy_o = (r_reg.cnt != '0);
   assign done_o = r_reg.done;

endmodule : hmc_stab_delay

`default_nettype wire

// ### test/hmc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// CPU side: passes a software halt request on as the halt signal, registered one cycle later
module hmc_cpu_model (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic halt_req_i,
   output var  logic halt_exec_o,
   output var  logic cpu_slow_o
);
   // Software moves to the slow clock before halting
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cpu_slow_o  <= 1'b0;
         halt_exec_o <= 1'b0;
      end else begin
         cpu_slow_o  <= cpu_slow_o | halt_req_i;
         halt_exec_o <= halt_req_i; // Halt only on request, wake pin set up
      end
   end
endmodule : hmc_cpu_model

`default_nettype wire

// ### test/halt_mode_controller_test.sv
`timescale 1ns/1ps
`default_nettype none

module halt_mode_controller_test;
   logic                clk_i     = 1'b0;
   logic                sys_rst_i = 1'b1;
   logic [1:0]          addr_i    = 2'h0;
   logic [7:0]          wdata_i   = 8'h00;
   logic                wr_i      = 1'b0;
   logic                rd_i      = 1'b0;
   logic                halt_req  = 1'b0;
   logic                lite      = 1'b0;
   logic                reload    = 1'b0;
   logic                awu       = 1'b0;
   logic                pin_n     = 1'b1;
   logic                wdg_act   = 1'b0;
   logic                wdg_opt   = 1'b0;
   logic [7:0]          irq_req   = 8'h00;
   logic                ce        = 1'b1;
   logic [7:0]          rdata;
   logic [7:0]          d;
   logic                halt_exec;
   logic                imask_clr;
   logic                irq_srv;
   logic                fetch_rst;
   logic                wdg_rst;
   hmc_pkg::hmc_clk_t   clk_en;
   hmc_pkg::hmc_cause_t cause;
   int                  errors     = 0;
   int                  num_checks = 0;
   int                  n;

   // Free-running 100 MHz clock
   always #5 clk_i = ~clk_i;

   hmc_cpu_model cpu (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .halt_req_i(halt_req), .halt_exec_o(halt_exec),
                      .cpu_slow_o());

   hmc_halt_mode_controller dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata), .halt_exec_i(halt_exec), .lite_timer_irq_i(lite),
      .reload_timer_irq_i(reload), .awu_irq_i(awu), .irq_req_i(irq_req), .rst_pin_n_i(pin_n),
      .wdg_active_i(wdg_act), .watchdog_halt_option_i(wdg_opt), .clk_en_o(clk_en), .imask_clear_o(imask_clr),
      .irq_service_o(irq_srv), .fetch_rst_vec_o(fetch_rst), .wdg_rst_o(wdg_rst), .wake_cause_o(cause));

   task close_out;
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   task rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 v = rdata;
   endtask : rd

   // Read the mode field of the status register
   task st(input logic [2:0] exp);
      rd(hmc_pkg::STAT_OFS, d);
      chk("state", 16'(d[2:0]), 16'(exp));
   endtask : st

   // Halt request through the CPU model; returns just after the edge that takes it
   task do_halt;
      @(posedge clk_i) halt_req <= 1'b1;
      @(posedge clk_i) halt_req <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask : do_halt

   // Count edges until the service or reset-fetch pulse, bounded
   task wake_wait(input logic is_fetch, output int cnt);
      cnt = 0;
      while (((is_fetch ? fetch_rst : irq_srv) !== 1'b1) && cnt < 400) begin
         @(posedge clk_i);
         #1 cnt++;
      end
   endtask : wake_wait

   // Hang guard well beyond the twelve hundred or so cycles the tests need
   initial begin
      #200000;
      errors++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1 chk("clk_en reset", 16'(clk_en), 16'(hmc_pkg::CLK_RUN));
      rd(hmc_pkg::CFG_OFS, d);
      chk("cfg reset", 16'(d), 16'(hmc_pkg::CFG_RST));
      rd(hmc_pkg::WAKE_MASK_OFS, d);
      chk("mask reset", 16'(d), 16'(hmc_pkg::WAKE_MASK_RST));
      wr(2'h3, 8'hff);
      rd(2'h3, d);
      chk("unmapped", 16'(d), 16'h0000);
      wr(hmc_pkg::STAT_OFS, 8'hff);
      st(3'h0);
      wr(hmc_pkg::CFG_OFS, 8'hff);
      rd(hmc_pkg::CFG_OFS, d);
      chk("cfg reserved", 16'(d), 16'h001f);
      // Every timer enable and clock select combination
      for (int i = 0; i < 16; i++) begin
         wr(hmc_pkg::CFG_OFS, 8'(i));
         rd(hmc_pkg::STAT_OFS, d);
         chk("act_en", 16'(d[3]), 16'(i[0] | (i[1] & ~i[3] & i[2])));
      end
      // Active-halt on the lite timer; external requests and auto-wakeup ignored
      wr(hmc_pkg::CFG_OFS, 8'h01);
      do_halt();
      chk("imask entry", 16'(imask_clr), 16'h0001);
      chk("gates act", 16'({clk_en.cpu, clk_en.osc, clk_en.periph, clk_en.lite_timer}), 16'h0005);
      st(3'h1);
      @(posedge clk_i) irq_req <= 8'hff;
      awu <= 1'b1;
      repeat (3) @(posedge clk_i);
      st(3'h1);
      @(posedge clk_i) irq_req <= 8'h00;
      awu  <= 1'b0;
      @(posedge clk_i) lite <= 1'b1;
      @(posedge clk_i);
      #1 chk("svc at once", 16'(irq_srv), 16'h0001);
      chk("cause timer", 16'(cause), 16'(hmc_pkg::CS_TIMER));
      chk("clk_en run", 16'(clk_en), 16'(hmc_pkg::CLK_RUN));
      @(posedge clk_i) lite <= 1'b0;
      #1 chk("svc pulse", 16'(irq_srv), 16'h0000);
      // Reload-timer active-halt with an interrupt already pending
      wr(hmc_pkg::CFG_OFS, 8'h06);
      @(posedge clk_i) reload <= 1'b1;
      do_halt();
      chk("imask entry2", 16'(imask_clr), 16'h0001);
      chk("gates reload", 16'({clk_en.lite_timer, clk_en.reload_timer}), 16'h0001);
      @(posedge clk_i);
      #1 chk("pending wake", 16'(irq_srv), 16'h0001);
      @(posedge clk_i) reload <= 1'b0;
      // Watchdog active, option clear
      @(posedge clk_i) wdg_act <= 1'b1;
      wr(hmc_pkg::CFG_OFS, 8'h00);
      do_halt();
      chk("wdg reset", 16'(wdg_rst), 16'h0001);
      st(3'h0);
      wr(hmc_pkg::CFG_OFS, 8'h01);
      do_halt();
      chk("wdg act-halt", 16'(wdg_rst), 16'h0000);
      st(3'h1);
      // Reset pin ends active-halt after the start-up delay
      @(posedge clk_i) pin_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      st(3'h4);
      @(posedge clk_i) pin_n <= 1'b1;
      wake_wait(1'b1, n);
      chk("rst delay", 16'(n >= 259 && n <= 263), 16'h0001);
      // Full halt, option set, masked wake request
      @(posedge clk_i) wdg_opt <= 1'b1;
      wr(hmc_pkg::CFG_OFS, 8'h00);
      wr(hmc_pkg::WAKE_MASK_OFS, 8'hfb);
      do_halt();
      chk("wdg opt set", 16'(wdg_rst), 16'h0000);
      chk("imask halt", 16'(imask_clr), 16'h0001);
      chk("gates halt", 16'({clk_en.cpu, clk_en.osc, clk_en.periph}), 16'h0000);
      @(posedge clk_i) irq_req <= 8'h04;
      repeat (3) @(posedge clk_i);
      st(3'h2);
      @(posedge clk_i) irq_req <= 8'h08;
      @(posedge clk_i);
      #1 chk("osc restart", 16'(clk_en.osc), 16'h0001);
      wake_wait(1'b0, n);
      chk("halt delay", 16'(n), 16'h0102);
      chk("cause ext", 16'(cause), 16'(hmc_pkg::CS_EXT));
      @(posedge clk_i) irq_req <= 8'h00;
      // Auto-wakeup halt
      wdg_act <= 1'b0;
      wr(hmc_pkg::CFG_OFS, 8'h10);
      do_halt();
      chk("gates awu", 16'({clk_en.osc, clk_en.awu_osc}), 16'h0001);
      st(3'h3);
      @(posedge clk_i) awu <= 1'b1;
      @(posedge clk_i);
      #1 wake_wait(1'b0, n);
      chk("awu delay", 16'(n), 16'h0102);
      chk("cause awu", 16'(cause), 16'(hmc_pkg::CS_AWU));
      @(posedge clk_i) awu <= 1'b0;
      // Clock enable low for ten edges stretches the delay by ten
      wr(hmc_pkg::CFG_OFS, 8'h00);
      do_halt();
      @(posedge clk_i) irq_req <= 8'h08;
      repeat (20) @(posedge clk_i);
      ce <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce <= 1'b1;
      wake_wait(1'b0, n);
      chk("ce freeze", 16'(n), 16'h00ef);
      chk("cause ext2", 16'(cause), 16'(hmc_pkg::CS_EXT));
      @(posedge clk_i) irq_req <= 8'h00;
      close_out();
   end
endmodule : halt_mode_controller_test

`default_nettype wire
